// [src/pfc_config_reg.sv]
// Contract
// - Write accepted only if all set bits are supported; else fault, no change.
// - Bits 31:1 visible to user code through identification query.
// - Core tag bits 39:32 copied into every event record.
// - Bits 47:40 give vector for ring-buffer threshold interrupt.
// - Whole register clears to zero on reset.
// - Value-sampling instruction allowed only while bit 1 set.
// - Retired instructions counted only while bit 2 set.
// - Retired branches counted only while bit 3 set.
// - Data-cache misses counted only while bit 4 set.
// - Unhalted core clock cycles counted only while bit 5 set.
// - Unhalted reference clock cycles counted only while bit 6 set.
// - Bit 29 set selects continuous mode, else synchronized mode.
// - Bit 30 with timestamp counter present stores timestamp in records.
// - Threshold interrupt raised only while bit 31 set.
// - Bit 0 and bits 28:7 reserved and can never be set.
`timescale 1ns/1ps
`default_nettype none
module pfc_config_reg
  import pfc_pkg::*;
#(
  parameter logic [PFC_ADDR_W-1:0] CFG_ADDR = PFC_CFG_ADDR,
  parameter int N_EVT = PFC_NUM_EVENTS
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic msr_req_in,
  input wire logic msr_write_in,
  input wire logic msr_priv_in,
  input wire logic [PFC_ADDR_W-1:0] msr_addr_in,
  input wire logic [PFC_DATA_W-1:0] msr_wdata_in,
  input wire logic [PFC_CAP_W-1:0] cap_word_in,
  output logic msr_done_out,
  output logic msr_gp_fault_out,
  output logic [PFC_DATA_W-1:0] msr_rdata_out,
  input wire logic cpuid_query_in,
  output logic cpuid_valid_out,
  output logic [PFC_CAP_W-1:0] cpuid_eax_out,
  input wire logic [N_EVT-1:0] event_in,
  output logic [N_EVT-1:0] event_count_out,
  input wire logic sample_insn_req_in,
  output logic sample_insn_ok_out,
  output logic sample_insn_ud_out,
  output logic free_running_mode_out,
  input wire logic record_req_in,
  input wire logic stamp_present_in,
  input wire logic [PFC_DATA_W-1:0] timestamp_in,
  output logic rec_valid_out,
  output logic [PFC_FIELD_W-1:0] rec_core_tag_out,
  output logic [PFC_DATA_W-1:0] rec_stamp_out,
  input wire logic ring_thresh_in,
  output logic thr_irq_out,
  output logic [PFC_FIELD_W-1:0] thr_vector_out
);
  logic [PFC_DATA_W-1:0] cfg_reg;
  logic [PFC_DATA_W-1:0] cfg_next;
  logic [PFC_DATA_W-1:0] rdata_reg;
  logic [PFC_DATA_W-1:0] rdata_next;
  logic done_reg;
  logic done_next;
  logic gp_reg;
  logic gp_next;
  logic [PFC_CAP_W-1:0] eax_reg;
  logic [PFC_CAP_W-1:0] eax_next;
  logic eax_valid_reg;
  logic eax_valid_next;

  logic addr_hit;
  logic acc;
  logic wr_try;
  logic rd_try;
  logic [PFC_DATA_W-1:0] allowed_mask;
  logic bad_bits;
  logic wr_ok;

  // Only this register's address is answered; others belong elsewhere
  assign addr_hit = (msr_addr_in == CFG_ADDR);
  assign acc = msr_req_in & addr_hit;
  assign wr_try = acc & msr_write_in;
  assign rd_try = acc & ~msr_write_in;

  // Feature bits need capability; tag and vector are free; reserved never
  assign allowed_mask = PFC_TAG_VEC_MASK |
    (PFC_DATA_W'(cap_word_in) & PFC_FEATURE_MASK);
  assign bad_bits = |(msr_wdata_in & ~allowed_mask);
  assign wr_ok = wr_try & msr_priv_in & ~bad_bits;

  always_comb begin
    cfg_next = cfg_reg;
    rdata_next = rdata_reg;
    done_next = acc;
    gp_next = 1'b0;
    if (acc && !msr_priv_in) begin
      // Unprivileged access faults in either direction
      gp_next = 1'b1;
    end else if (wr_try) begin
      if (bad_bits) begin
        gp_next = 1'b1;
      end else begin
        cfg_next = msr_wdata_in;
      end
    end else if (rd_try) begin
      rdata_next = cfg_reg;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_reg <= PFC_CFG_RESET;
      rdata_reg <= PFC_CFG_RESET;
      done_reg <= 1'b0;
      gp_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      gp_reg <= gp_next;
    end
  end

  assign msr_done_out = done_reg;
  assign msr_gp_fault_out = gp_reg;
  assign msr_rdata_out = rdata_reg;

  // Identification query: enabled features mirrored for user code
  always_comb begin
    eax_next = eax_reg;
    eax_valid_next = cpuid_query_in;
    if (cpuid_query_in) begin
      eax_next = cfg_reg[PFC_CAP_W-1:0];
      eax_next[PFC_CAP_AVAIL_BIT] = cap_word_in[PFC_CAP_AVAIL_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      eax_reg <= '0;
      eax_valid_reg <= 1'b0;
    end else begin
      eax_reg <= eax_next;
      eax_valid_reg <= eax_valid_next;
    end
  end

  assign cpuid_eax_out = eax_reg;
  assign cpuid_valid_out = eax_valid_reg;

  assign free_running_mode_out = cfg_reg[PFC_BIT_FREE_RUN];

  pfc_event_gate #(
    .N_EVT(N_EVT)
  ) u_event_gate (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .evt_allow_in(cfg_reg[PFC_BIT_EVT_LSB +: N_EVT]),
    .sample_allow_in(cfg_reg[PFC_BIT_SAMPLE]),
    .event_in(event_in),
    .sample_insn_req_in(sample_insn_req_in),
    .event_count_out(event_count_out),
    .sample_insn_ok_out(sample_insn_ok_out),
    .sample_insn_ud_out(sample_insn_ud_out)
  );

  pfc_record_stamp #(
    .FIELD_W(PFC_FIELD_W),
    .STAMP_W(PFC_DATA_W)
  ) u_record_stamp (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .core_tag_in(cfg_reg[PFC_TAG_LSB +: PFC_FIELD_W]),
    .vector_in(cfg_reg[PFC_VEC_LSB +: PFC_FIELD_W]),
    .stamp_allow_in(cfg_reg[PFC_BIT_STAMP]),
    .thr_allow_in(cfg_reg[PFC_BIT_THR_INT]),
    .record_req_in(record_req_in),
    .stamp_present_in(stamp_present_in),
    .timestamp_in(timestamp_in),
    .ring_thresh_in(ring_thresh_in),
    .rec_valid_out(rec_valid_out),
    .rec_core_tag_out(rec_core_tag_out),
    .rec_stamp_out(rec_stamp_out),
    .thr_irq_out(thr_irq_out),
    .thr_vector_out(thr_vector_out)
  );

  property p_bad_write;
    @(posedge clk_in) disable iff (!arst_n_in)
    (wr_try && msr_priv_in && bad_bits) |=>
      msr_gp_fault_out && msr_done_out && $stable(cfg_reg);
  endproperty
  a_bad_write: assert property (p_bad_write)
    else $error("unsupported write not faulted or register changed");

  property p_good_write;
    @(posedge clk_in) disable iff (!arst_n_in)
    wr_ok |=>
      !msr_gp_fault_out && cfg_reg == $past(msr_wdata_in);
  endproperty
  a_good_write: assert property (p_good_write)
    else $error("legal write not stored");

  property p_no_change;
    @(posedge clk_in) disable iff (!arst_n_in)
    !(wr_try && msr_priv_in) |=> $stable(cfg_reg);
  endproperty
  a_no_change: assert property (p_no_change)
    else $error("register changed without accepted write");

  property p_read_back;
    @(posedge clk_in) disable iff (!arst_n_in)
    (rd_try && msr_priv_in) |=>
      msr_done_out && !msr_gp_fault_out && msr_rdata_out == $past(cfg_reg);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read did not return stored value");

  property p_reset_zero;
    @(posedge clk_in)
    !arst_n_in |-> cfg_reg == PFC_CFG_RESET && msr_rdata_out == PFC_CFG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("register not zero during reset");

  property p_reserved_clear;
    @(posedge clk_in) disable iff (!arst_n_in)
    (cfg_reg & PFC_RSVD_MASK) == '0;
  endproperty
  a_reserved_clear: assert property (p_reserved_clear)
    else $error("reserved bit set in configuration");

  property p_cap_bound;
    @(posedge clk_in) disable iff (!arst_n_in)
    wr_ok |=>
      (cfg_reg[PFC_CAP_W-1:0] & ~$past(cap_word_in)) == '0;
  endproperty
  a_cap_bound: assert property (p_cap_bound)
    else $error("unsupported feature bit accepted");

  property p_cpuid_vis;
    @(posedge clk_in) disable iff (!arst_n_in)
    cpuid_query_in |=> cpuid_valid_out &&
      cpuid_eax_out[PFC_VIS_MSB:PFC_VIS_LSB] ==
      $past(cfg_reg[PFC_VIS_MSB:PFC_VIS_LSB]);
  endproperty
  a_cpuid_vis: assert property (p_cpuid_vis)
    else $error("identification query does not mirror bits 31:1");

  property p_free_run;
    @(posedge clk_in) disable iff (!arst_n_in)
    wr_ok |=>
      free_running_mode_out == $past(msr_wdata_in[PFC_BIT_FREE_RUN]);
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("mode select does not follow bit 29");

  property p_unpriv_fault;
    @(posedge clk_in) disable iff (!arst_n_in)
    (acc && !msr_priv_in) |=> msr_gp_fault_out ##1 !msr_gp_fault_out
      || $past(acc, 1);
  endproperty
  a_unpriv_fault: assert property (p_unpriv_fault)
    else $error("unprivileged access not faulted");

  property p_done_only_hit;
    @(posedge clk_in) disable iff (!arst_n_in)
    msr_done_out |-> $past(acc);
  endproperty
  a_done_only_hit: assert property (p_done_only_hit)
    else $error("answer without request to this register");

  property p_evt_route;
    @(posedge clk_in) disable iff (!arst_n_in)
    (event_in != '0) |=> event_count_out ==
      ($past(event_in) & $past(cfg_reg[PFC_BIT_EVT_LSB +: N_EVT]));
  endproperty
  a_evt_route: assert property (p_evt_route)
    else $error("event not gated by its configuration bit");

  property p_sample_src;
    @(posedge clk_in) disable iff (!arst_n_in)
    sample_insn_req_in |=>
      sample_insn_ok_out == $past(cfg_reg[PFC_BIT_SAMPLE]);
  endproperty
  a_sample_src: assert property (p_sample_src)
    else $error("sample instruction not gated by its allow bit");

  property p_rec_tag_src;
    @(posedge clk_in) disable iff (!arst_n_in)
    record_req_in |=>
      rec_core_tag_out == $past(cfg_reg[PFC_TAG_LSB +: PFC_FIELD_W]);
  endproperty
  a_rec_tag_src: assert property (p_rec_tag_src)
    else $error("record core tag not taken from configuration");

  property p_irq_src;
    @(posedge clk_in) disable iff (!arst_n_in)
    thr_irq_out |-> $past(ring_thresh_in) && $past(cfg_reg[PFC_BIT_THR_INT])
      && thr_vector_out == $past(cfg_reg[PFC_VEC_LSB +: PFC_FIELD_W]);
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("threshold interrupt without allow bit or wrong vector");

  property p_miss_quiet;
    @(posedge clk_in) disable iff (!arst_n_in)
    (msr_req_in && !addr_hit) |=> !msr_done_out && $stable(cfg_reg);
  endproperty
  a_miss_quiet: assert property (p_miss_quiet)
    else $error("access to another address answered or stored");
endmodule : pfc_config_reg
`default_nettype wire

// [src/pfc_pkg.sv]
package pfc_pkg;
  localparam int PFC_DATA_W = 64;
  localparam int PFC_ADDR_W = 32;
  localparam int PFC_CAP_W = 32;
  localparam int PFC_FIELD_W = 8;
  localparam int PFC_NUM_EVENTS = 5;
  localparam logic [PFC_ADDR_W-1:0] PFC_CFG_ADDR = 32'hc000_0105;
  localparam logic [PFC_DATA_W-1:0] PFC_CFG_RESET = 64'h0;
  // Feature bits that a capability word may unlock
  localparam logic [PFC_DATA_W-1:0] PFC_FEATURE_MASK = 64'h0000_0000_e000_007e;
  // Core tag and vector fields, always writable
  localparam logic [PFC_DATA_W-1:0] PFC_TAG_VEC_MASK = 64'h0000_ffff_0000_0000;
  localparam logic [PFC_DATA_W-1:0] PFC_RSVD_MASK = 64'hffff_0000_1fff_ff81;
  localparam int PFC_BIT_SAMPLE = 1;
  localparam int PFC_BIT_EVT_LSB = 2;
  localparam int PFC_BIT_FREE_RUN = 29;
  localparam int PFC_BIT_STAMP = 30;
  localparam int PFC_BIT_THR_INT = 31;
  localparam int PFC_TAG_LSB = 32;
  localparam int PFC_VEC_LSB = 40;
  localparam int PFC_VIS_LSB = 1;
  localparam int PFC_VIS_MSB = 31;
  localparam int PFC_CAP_AVAIL_BIT = 0;
endpackage : pfc_pkg

// [src/pfc_event_gate.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_event_gate
  import pfc_pkg::*;
#(
  parameter int N_EVT = PFC_NUM_EVENTS
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [N_EVT-1:0] evt_allow_in,
  input wire logic sample_allow_in,
  input wire logic [N_EVT-1:0] event_in,
  input wire logic sample_insn_req_in,
  output logic [N_EVT-1:0] event_count_out,
  output logic sample_insn_ok_out,
  output logic sample_insn_ud_out
);
  logic [N_EVT-1:0] cnt_reg;
  logic [N_EVT-1:0] cnt_next;
  logic ok_reg;
  logic ok_next;
  logic ud_reg;
  logic ud_next;

  genvar gi;
  generate
    for (gi = 0; gi < N_EVT; gi++) begin : g_evt
      // Event pulse passes only while its allow bit is set
      assign cnt_next[gi] = event_in[gi] & evt_allow_in[gi];
    end
  endgenerate

  always_comb begin
    ok_next = sample_insn_req_in & sample_allow_in;
    ud_next = sample_insn_req_in & ~sample_allow_in;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= '0;
      ok_reg <= 1'b0;
      ud_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      ok_reg <= ok_next;
      ud_reg <= ud_next;
    end
  end

  assign event_count_out = cnt_reg;
  assign sample_insn_ok_out = ok_reg;
  assign sample_insn_ud_out = ud_reg;

  property p_evt_gated;
    @(posedge clk_in) disable iff (!arst_n_in)
    (event_count_out != '0) |->
      ((event_count_out & ~$past(evt_allow_in)) == '0);
  endproperty
  a_evt_gated: assert property (p_evt_gated)
    else $error("event counted while its allow bit was clear");

  property p_sample_gate;
    @(posedge clk_in) disable iff (!arst_n_in)
    sample_insn_req_in |=> (sample_insn_ok_out == $past(sample_allow_in))
      && (sample_insn_ud_out != sample_insn_ok_out);
  endproperty
  a_sample_gate: assert property (p_sample_gate)
    else $error("sample instruction gating wrong");
endmodule : pfc_event_gate
`default_nettype wire

// [src/pfc_record_stamp.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_record_stamp
  import pfc_pkg::*;
#(
  parameter int FIELD_W = PFC_FIELD_W,
  parameter int STAMP_W = PFC_DATA_W
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [FIELD_W-1:0] core_tag_in,
  input wire logic [FIELD_W-1:0] vector_in,
  input wire logic stamp_allow_in,
  input wire logic thr_allow_in,
  input wire logic record_req_in,
  input wire logic stamp_present_in,
  input wire logic [STAMP_W-1:0] timestamp_in,
  input wire logic ring_thresh_in,
  output logic rec_valid_out,
  output logic [FIELD_W-1:0] rec_core_tag_out,
  output logic [STAMP_W-1:0] rec_stamp_out,
  output logic thr_irq_out,
  output logic [FIELD_W-1:0] thr_vector_out
);
  logic valid_reg;
  logic valid_next;
  logic [FIELD_W-1:0] tag_reg;
  logic [FIELD_W-1:0] tag_next;
  logic [STAMP_W-1:0] stamp_reg;
  logic [STAMP_W-1:0] stamp_next;
  logic irq_reg;
  logic irq_next;
  logic [FIELD_W-1:0] vec_reg;
  logic [FIELD_W-1:0] vec_next;

  always_comb begin
    valid_next = record_req_in;
    tag_next = tag_reg;
    stamp_next = stamp_reg;
    if (record_req_in) begin
      tag_next = core_tag_in;
      // Timestamp field stays zero unless storing is allowed and present
      stamp_next = (stamp_allow_in && stamp_present_in) ?
        timestamp_in : '0;
    end
    irq_next = ring_thresh_in & thr_allow_in;
    vec_next = vec_reg;
    if (ring_thresh_in && thr_allow_in) begin
      vec_next = vector_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valid_reg <= 1'b0;
      tag_reg <= '0;
      stamp_reg <= '0;
      irq_reg <= 1'b0;
      vec_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      tag_reg <= tag_next;
      stamp_reg <= stamp_next;
      irq_reg <= irq_next;
      vec_reg <= vec_next;
    end
  end

  assign rec_valid_out = valid_reg;
  assign rec_core_tag_out = tag_reg;
  assign rec_stamp_out = stamp_reg;
  assign thr_irq_out = irq_reg;
  assign thr_vector_out = vec_reg;

  property p_rec_tag;
    @(posedge clk_in) disable iff (!arst_n_in)
    record_req_in |=> rec_valid_out && rec_core_tag_out == $past(core_tag_in);
  endproperty
  a_rec_tag: assert property (p_rec_tag)
    else $error("record core tag not copied");

  property p_rec_stamp;
    @(posedge clk_in) disable iff (!arst_n_in)
    record_req_in |=> rec_stamp_out == (($past(stamp_allow_in)
      && $past(stamp_present_in)) ? $past(timestamp_in) : '0);
  endproperty
  a_rec_stamp: assert property (p_rec_stamp)
    else $error("record timestamp field wrong");

  property p_irq_vec;
    @(posedge clk_in) disable iff (!arst_n_in)
    thr_irq_out |-> $past(thr_allow_in) && thr_vector_out == $past(vector_in);
  endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("threshold interrupt gating or vector wrong");
endmodule : pfc_record_stamp
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pfc_pkg::*;
;
  typedef struct packed {
    logic [1:0] kind;
    logic [95:0] val;
  } pfc_note_s;
  logic clk_in, arst_n_in, msr_req_in, msr_write_in, msr_priv_in;
  logic [PFC_ADDR_W-1:0] msr_addr_in;
  logic [PFC_DATA_W-1:0] msr_wdata_in, msr_rdata_out, timestamp_in;
  logic [PFC_DATA_W-1:0] rec_stamp_out;
  logic [PFC_CAP_W-1:0] cap_word_in, cpuid_eax_out;
  logic msr_done_out, msr_gp_fault_out, cpuid_query_in, cpuid_valid_out;
  logic [PFC_NUM_EVENTS-1:0] event_in, event_count_out;
  logic sample_insn_req_in, sample_insn_ok_out, sample_insn_ud_out;
  logic free_running_mode_out, record_req_in, stamp_present_in;
  logic rec_valid_out, ring_thresh_in, thr_irq_out;
  logic [PFC_FIELD_W-1:0] rec_core_tag_out, thr_vector_out;
  logic [63:0] cfg_m, rdata_m, rnd;
  logic [7:0] vec_m;
  pfc_note_s q[$];
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  pfc_config_reg pfc_config_reg_i (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .msr_req_in(msr_req_in),
    .msr_write_in(msr_write_in), .msr_priv_in(msr_priv_in),
    .msr_addr_in(msr_addr_in), .msr_wdata_in(msr_wdata_in),
    .cap_word_in(cap_word_in), .msr_done_out(msr_done_out),
    .msr_gp_fault_out(msr_gp_fault_out), .msr_rdata_out(msr_rdata_out),
    .cpuid_query_in(cpuid_query_in), .cpuid_valid_out(cpuid_valid_out),
    .cpuid_eax_out(cpuid_eax_out), .event_in(event_in),
    .event_count_out(event_count_out),
    .sample_insn_req_in(sample_insn_req_in),
    .sample_insn_ok_out(sample_insn_ok_out),
    .sample_insn_ud_out(sample_insn_ud_out),
    .free_running_mode_out(free_running_mode_out),
    .record_req_in(record_req_in), .stamp_present_in(stamp_present_in),
    .timestamp_in(timestamp_in), .rec_valid_out(rec_valid_out),
    .rec_core_tag_out(rec_core_tag_out), .rec_stamp_out(rec_stamp_out),
    .ring_thresh_in(ring_thresh_in), .thr_irq_out(thr_irq_out),
    .thr_vector_out(thr_vector_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic fail(input string m);
    n_errors++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask : fail

  task automatic check(input logic [95:0] seen, exp, input string m);
    compares++;
    if (seen !== exp) fail(m);
  endtask : check

  task automatic final_report;
    $display("counts: compares=%0d errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic push(input logic [1:0] k, input logic [95:0] v);
    q.push_back('{kind: k, val: v});
  endtask : push

  task automatic take(input logic [1:0] k, input logic [95:0] v);
    pfc_note_s n;
    if (q.size() == 0) begin
      fail("unexpected result");
    end else begin
      n = q.pop_front();
      check({94'h0, k}, {94'h0, n.kind}, "result kind");
      check(v, n.val, "result value");
    end
  endtask : take

  always @(negedge clk_in) begin
    if (arst_n_in === 1'b1) begin
      if (msr_done_out !== 1'b0)
        take(2'd0, {31'h0, msr_gp_fault_out, msr_rdata_out});
      if (cpuid_valid_out !== 1'b0)
        take(2'd1, {64'h0, cpuid_eax_out});
      if (rec_valid_out !== 1'b0)
        take(2'd2, {15'h0, thr_irq_out, thr_vector_out, rec_core_tag_out,
                    rec_stamp_out});
      if ((sample_insn_ok_out | sample_insn_ud_out) !== 1'b0)
        take(2'd3, {89'h0, sample_insn_ok_out, sample_insn_ud_out,
                    event_count_out});
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic strobes(input logic [3:0] s);
    {msr_req_in, cpuid_query_in, sample_insn_req_in, record_req_in} = s;
    if (!s[1]) event_in = '0;
    if (!s[0]) ring_thresh_in = 1'b0;
  endtask : strobes
  task automatic idle;
    @(negedge clk_in);
    strobes(4'h0);
  endtask : idle

  task automatic msr(input logic w, p, input logic [31:0] a,
                     input logic [63:0] d);
    logic ok;
    @(negedge clk_in);
    strobes(4'h8);
    msr_write_in = w;
    msr_priv_in = p;
    msr_addr_in = a;
    msr_wdata_in = d;
    ok = p && ((d & ~(PFC_TAG_VEC_MASK |
          ({32'h0, cap_word_in} & PFC_FEATURE_MASK))) == 64'h0);
    if (a == PFC_CFG_ADDR) begin
      if (w && ok) cfg_m = d;
      if (!w && p) rdata_m = cfg_m;
      push(2'd0, {31'h0, w ? !ok : !p, rdata_m});
    end
  endtask : msr

  task automatic query;
    @(negedge clk_in);
    strobes(4'h4);
    push(2'd1, {64'h0, cfg_m[31:1], cap_word_in[0]});
  endtask : query

  task automatic evt(input logic [4:0] e);
    @(negedge clk_in);
    event_in = e;
    strobes(4'h2);
    push(2'd3, {89'h0, cfg_m[1], !cfg_m[1], e & cfg_m[6:2]});
  endtask : evt

  task automatic rec(input logic pr, th, input logic [63:0] ts);
    logic irq;
    @(negedge clk_in);
    strobes(4'h1);
    stamp_present_in = pr;
    ring_thresh_in = th;
    timestamp_in = ts;
    irq = th & cfg_m[31];
    if (irq) vec_m = cfg_m[47:40];
    push(2'd2, {15'h0, irq, vec_m, cfg_m[39:32],
                (cfg_m[30] & pr) ? ts : 64'h0});
  endtask : rec

  task automatic wr_rand;
    rnd = {$urandom, $urandom} & (PFC_FEATURE_MASK | PFC_TAG_VEC_MASK);
    rnd[39:32] = 8'($urandom >> 24);
    if (rnd[31]) rnd[47:46] = 2'b01;
    msr(1'b1, 1'b1, PFC_CFG_ADDR, rnd);
  endtask : wr_rand

  initial begin
    {arst_n_in, msr_req_in, msr_write_in, msr_priv_in} = '0;
    {cpuid_query_in, record_req_in, stamp_present_in, ring_thresh_in} = '0;
    {sample_insn_req_in, event_in, msr_addr_in, msr_wdata_in} = '0;
    timestamp_in = '0;
    cap_word_in = 32'h0000_0001;
    {cfg_m, rdata_m, vec_m} = '0;
    void'($urandom(32'h3840));
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    arst_n_in = 1'b1;
    msr(1'b0, 1'b1, PFC_CFG_ADDR, '0);
    query();
    idle();
    $display("test reset_values done");
    for (int b = 0; b < 64; b++)
      if (!PFC_TAG_VEC_MASK[b])
        msr(1'b1, 1'b1, PFC_CFG_ADDR, 64'h1 << b);
    cap_word_in = 32'hffff_ffff;
    for (int b = 0; b < 64; b++)
      msr(1'b1, 1'b1, PFC_CFG_ADDR, 64'h1 << b);
    msr(1'b0, 1'b1, PFC_CFG_ADDR, '0);
    idle();
    $display("test capability_gating done");
    wr_rand();
    msr(1'b1, 1'b0, PFC_CFG_ADDR, 64'h0000_1234_e000_007e);
    msr(1'b0, 1'b0, PFC_CFG_ADDR, '0);
    msr(1'b1, 1'b1, PFC_CFG_ADDR + 32'h1, '0);
    msr(1'b0, 1'b1, PFC_CFG_ADDR - 32'h1, '0);
    msr(1'b0, 1'b1, PFC_CFG_ADDR, '0);
    idle();
    $display("test refused_access done");
    repeat (20) begin
      cap_word_in = $urandom;
      wr_rand();
      msr(1'b0, 1'b1, PFC_CFG_ADDR, '0);
      query();
      idle();
      check(96'(free_running_mode_out), 96'(cfg_m[29]), "mode");
    end
    $display("test readback_visibility done");
    cap_word_in = 32'hffff_ffff;
    repeat (20) begin
      wr_rand();
      repeat (3) evt(5'($urandom));
      idle();
    end
    $display("test event_gating done");
    repeat (20) begin
      wr_rand();
      repeat (2) rec(1'($urandom), 1'($urandom), {$urandom, $urandom});
      idle();
    end
    $display("test record_fields done");
    repeat (3) @(negedge clk_in);
    check(96'(q.size()), 96'h0, "results missing");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
